/* hdl/hdc_consts.svh */
// register offsets, field positions and reset values of the hottest compare
// block; assumes inclusion from the block's design file only
`ifndef HDC_CONSTS_SVH
`define HDC_CONSTS_SVH

// ************************************************************
// register offsets
// ************************************************************
`define HDC_OFS_EXT1_PMAX_FRAC  8'h4E
`define HDC_OFS_EXT2_PMAX_FRAC  8'h50
`define HDC_OFS_FILTER_SEL      8'h51
`define HDC_OFS_HOT_INT         8'h6A
`define HDC_OFS_HOT_FRAC        8'h6B
`define HDC_OFS_HOT_FLAGS       8'h6C
`define HDC_OFS_HOT_CFG         8'h6D

// ************************************************************
// field positions and reset values
// ************************************************************
`define HDC_FRAC_MSB            7
`define HDC_FRAC_LSB            5
`define HDC_FILTER_MSB          1
`define HDC_FILTER_LSB          0
`define HDC_CFG_REMEMBER_HOT_EN_BIT      5
`define HDC_CFG_EN_MSB          4
`define HDC_RST_CFG             6'h00
`define HDC_RST_FILTER          2'h0
`define HDC_RST_BYTE            8'h00

`endif

/* hdl/hdc_pkg.sv */
// types shared by the hottest compare block
// assumes the constants header sits beside it in hdl/
package hdc_pkg;
  typedef logic [7:0] hdc_byte_t;
  typedef logic [2:0] hdc_frac_t;
  typedef logic [4:0] hdc_chan_t;
  // register port transfer phases
  typedef enum logic [1:0] {
    HDC_IDLE = 2'b01,
    HDC_DONE = 2'b10
  } hdc_acc_e;
endpackage

/* hdl/hdc_hottest_regs.sv */
// hottest-of-five temperature compare with its register window
// assumes a register port driven by the serial interface logic: one-cycle
// read and write strobes with a byte address, data valid with the strobe
//
// Operation
// - period max fraction of external diodes 1, 2 shown in bits 7:5
// - filter select register bits 1:0 set external diode filter level
// - hottest channel integer byte read-only in hottest integer register
// - hottest fraction in bits 7:5, each step 0.125 degrees
// - status bit 4..1 ext diodes 4..1, bit 0 internal, set means hottest
// - five read-write compare enables in config bits 4:0, reset zero
// - remember-hottest bit 5 raises alert when hottest channel changes
`timescale 1ns/10ps
`include "hdc_consts.svh"

module hdc_hottest_regs #(
  parameter int NCHAN = 5                       // internal plus four external
) (
  input  wire logic          clk,               // 100 MHz clock
  input  wire logic          srst,              // sync reset, active high
  input  wire logic          reg_wr,            // register write strobe
  input  wire logic          reg_rd,            // register read strobe
  input  wire logic [7:0]    reg_addr,          // register byte address
  input  wire logic [7:0]    reg_wdata,         // write data
  output logic [7:0]         reg_rdata,         // read data, held after read
  output logic               reg_rvalid,        // read data valid pulse
  input  wire logic          sample_valid,      // new sample set strobe
  input  wire logic [10:0]   temp_in [5],       // {int, frac} per channel
  input  wire logic          pmax_valid,        // period max update strobe
  input  wire logic [2:0]    ext1_pmax_frac_in, // ext 1 period max fraction
  input  wire logic [2:0]    ext2_pmax_frac_in, // ext 2 period max fraction
  output logic [1:0]         filter_level,      // filter level to converter
  output logic               alert              // hottest change alert
);
  import hdc_pkg::*;

  // pick and value functions unroll for exactly five channels
  if (NCHAN != 5) begin : g_nchan_check
    $error("hdc_hottest_regs serves exactly five channels");
  end

  // ************************************************************
  // state and next values
  // ************************************************************
  logic [5:0]  cfg_reg,    cfg_next;
  logic [1:0]  filt_reg,   filt_next;
  hdc_frac_t   pm1_reg,    pm1_next;
  hdc_frac_t   pm2_reg,    pm2_next;
  hdc_byte_t   hint_reg,   hint_next;
  hdc_frac_t   hfrac_reg,  hfrac_next;
  hdc_chan_t   flags_reg,  flags_next;
  logic        alert_reg,  alert_next;
  hdc_byte_t   rdata_reg,  rdata_next;
  logic        rvalid_reg, rvalid_next;
  hdc_acc_e    acc_reg,    acc_next;

  // one-hot pick of the hottest enabled channel; ties keep the lower index
  function automatic hdc_chan_t pick_hot(input hdc_chan_t en,
                                         input logic [10:0] t [5]);
    hdc_chan_t   sel;
    logic [10:0] best;
    sel  = '0;
    best = '0;
    for (int i = 0; i < 5; i++) begin
      if (en[i] && (sel == '0 || t[i] > best)) begin
        sel  = hdc_chan_t'(5'h01 << i);
        best = t[i];
      end
    end
    return sel;
  endfunction

  // value of the channel flagged in a one-hot vector
  function automatic logic [10:0] hot_val(input hdc_chan_t sel,
                                          input logic [10:0] t [5]);
    logic [10:0] v;
    v = '0;
    for (int i = 0; i < 5; i++) begin
      if (sel[i]) begin
        v = t[i];
      end
    end
    return v;
  endfunction

  // ************************************************************
  // next state
  // ************************************************************
  // writes, sample capture and readback; the alert is held until reset or
  // the remember bit is cleared, since no clear path is given elsewhere
  always_comb begin
    hdc_chan_t   pick;
    logic [10:0] hv;
    pick        = pick_hot(cfg_reg[`HDC_CFG_EN_MSB:0], temp_in);
    hv          = hot_val(pick, temp_in);
    cfg_next    = cfg_reg;
    filt_next   = filt_reg;
    pm1_next    = pm1_reg;
    pm2_next    = pm2_reg;
    hint_next   = hint_reg;
    hfrac_next  = hfrac_reg;
    flags_next  = flags_reg;
    alert_next  = alert_reg & cfg_reg[`HDC_CFG_REMEMBER_HOT_EN_BIT];
    rdata_next  = rdata_reg;
    rvalid_next = 1'b0;
    acc_next    = HDC_IDLE;
    if (reg_wr) begin
      case (reg_addr)
        `HDC_OFS_HOT_CFG:    cfg_next  = reg_wdata[5:0];
        `HDC_OFS_FILTER_SEL: filt_next = reg_wdata[1:0];
        default:             cfg_next  = cfg_reg;
      endcase
    end
    if (pmax_valid) begin
      pm1_next = ext1_pmax_frac_in;
      pm2_next = ext2_pmax_frac_in;
    end
    if (sample_valid) begin
      flags_next = pick;
      hint_next  = hv[10:3];
      hfrac_next = hv[2:0];
      if (cfg_reg[`HDC_CFG_REMEMBER_HOT_EN_BIT] && pick != flags_reg) begin
        alert_next = 1'b1;
      end
    end
    if (reg_rd) begin
      rvalid_next = 1'b1;
      acc_next    = HDC_DONE;
      case (reg_addr)
        `HDC_OFS_EXT1_PMAX_FRAC: rdata_next = {pm1_reg, 5'h00};
        `HDC_OFS_EXT2_PMAX_FRAC: rdata_next = {pm2_reg, 5'h00};
        `HDC_OFS_FILTER_SEL:     rdata_next = {6'h00, filt_reg};
        `HDC_OFS_HOT_INT:        rdata_next = hint_reg;
        `HDC_OFS_HOT_FRAC:       rdata_next = {hfrac_reg, 5'h00};
        `HDC_OFS_HOT_FLAGS:      rdata_next = {3'h0, flags_reg};
        `HDC_OFS_HOT_CFG:        rdata_next = {2'h0, cfg_reg};
        default:                 rdata_next = `HDC_RST_BYTE;
      endcase
    end
  end

  // ************************************************************
  // registers
  // ************************************************************
  always_ff @(posedge clk) begin
    if (srst) begin
      cfg_reg    <= `HDC_RST_CFG;
      filt_reg   <= `HDC_RST_FILTER;
      pm1_reg    <= '0;
      pm2_reg    <= '0;
      hint_reg   <= `HDC_RST_BYTE;
      hfrac_reg  <= '0;
      flags_reg  <= '0;
      alert_reg  <= 1'b0;
      rdata_reg  <= `HDC_RST_BYTE;
      rvalid_reg <= 1'b0;
      acc_reg    <= HDC_IDLE;
    end else begin
      cfg_reg    <= cfg_next;
      filt_reg   <= filt_next;
      pm1_reg    <= pm1_next;
      pm2_reg    <= pm2_next;
      hint_reg   <= hint_next;
      hfrac_reg  <= hfrac_next;
      flags_reg  <= flags_next;
      alert_reg  <= alert_next;
      rdata_reg  <= rdata_next;
      rvalid_reg <= rvalid_next;
      acc_reg    <= acc_next;
    end
  end

  // outputs straight from flip-flops
  assign reg_rdata    = rdata_reg;
  assign reg_rvalid   = rvalid_reg;
  assign filter_level = filt_reg;
  assign alert        = alert_reg;

  // ************************************************************
  // assertions
  // ************************************************************
  property p_cfg_write;
    @(posedge clk) disable iff (srst)
    reg_wr && reg_addr == `HDC_OFS_HOT_CFG
      |=> cfg_reg == $past(reg_wdata[5:0]);
  endproperty
  a_cfg_write: assert property (p_cfg_write)
    else $error("config write not stored");

  property p_filter;
    @(posedge clk) disable iff (srst)
    reg_wr && reg_addr == `HDC_OFS_FILTER_SEL
      |=> filter_level == $past(reg_wdata[1:0]);
  endproperty
  a_filter: assert property (p_filter)
    else $error("filter level not taken from write");

  property p_onehot;
    @(posedge clk) disable iff (srst) $onehot0(flags_reg);
  endproperty
  a_onehot: assert property (p_onehot)
    else $error("more than one hottest flag");

  property p_flag_enabled;
    @(posedge clk) disable iff (srst)
    sample_valid |=> (flags_reg & ~$past(cfg_reg[4:0])) == 5'h00;
  endproperty
  a_flag_enabled: assert property (p_flag_enabled)
    else $error("disabled channel flagged hottest");

  property p_hot_int;
    @(posedge clk) disable iff (srst)
    reg_rd && reg_addr == `HDC_OFS_HOT_INT
      |=> reg_rvalid && reg_rdata == $past(hint_reg);
  endproperty
  a_hot_int: assert property (p_hot_int)
    else $error("hottest integer readback wrong");

  property p_hot_frac;
    @(posedge clk) disable iff (srst)
    reg_rd && reg_addr == `HDC_OFS_HOT_FRAC
      |=> reg_rdata == {$past(hfrac_reg), 5'h00};
  endproperty
  a_hot_frac: assert property (p_hot_frac)
    else $error("hottest fraction readback wrong");

  // every read is answered exactly one cycle later, never twice
  property p_rd_answer;
    @(posedge clk) disable iff (srst)
    reg_rd |=> reg_rvalid && acc_reg == HDC_DONE;
  endproperty
  a_rd_answer: assert property (p_rd_answer)
    else $error("read not answered one cycle later");

  property p_rd_quiet;
    @(posedge clk) disable iff (srst)
    !reg_rd |=> !reg_rvalid && acc_reg == HDC_IDLE;
  endproperty
  a_rd_quiet: assert property (p_rd_quiet)
    else $error("read valid without a read");

  property p_pmax;
    @(posedge clk) disable iff (srst)
    pmax_valid ##1 reg_rd && reg_addr == `HDC_OFS_EXT2_PMAX_FRAC && !pmax_valid
      |=> reg_rdata[7:5] == $past(ext2_pmax_frac_in, 2);
  endproperty
  a_pmax: assert property (p_pmax)
    else $error("period max fraction not shown");

  sequence s_hot_change;
    sample_valid && cfg_reg[5] &&
      pick_hot(cfg_reg[4:0], temp_in) != flags_reg;
  endsequence
  property p_alert;
    @(posedge clk) disable iff (srst) s_hot_change |=> alert;
  endproperty
  a_alert: assert property (p_alert)
    else $error("alert missing on hottest change");

  property p_alert_off;
    @(posedge clk) disable iff (srst) !cfg_reg[5] |=> !alert;
  endproperty
  a_alert_off: assert property (p_alert_off)
    else $error("alert raised with remember off");
endmodule

/* dv/hdc_host_model.sv */
// register port master standing in for the serial bus host
// assumes one-cycle strobes and a read answer within a few cycles
`timescale 1ns/10ps
module hdc_host_model (
  input  wire logic       clk,        // block clock
  output logic            reg_wr,     // write strobe
  output logic            reg_rd,     // read strobe
  output logic [7:0]      reg_addr,   // byte address
  output logic [7:0]      reg_wdata,  // write data
  input  wire logic [7:0] reg_rdata,  // read data
  input  wire logic       reg_rvalid  // read data valid
);
  // idle strobes low at time zero
  initial begin
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    reg_addr = 8'h00;
    reg_wdata = 8'h00;
  end
  // released address and data show the inverse, never a stale value
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    reg_wr = 1'b1;
    reg_addr = a;
    reg_wdata = d;
    @(posedge clk);
    #1;
    reg_wr = 1'b0;
    reg_addr = ~a;
    reg_wdata = ~d;
    // one idle edge so a following call never re-drives in this time step
    @(posedge clk);
    #1;
  endtask
  // answer is taken in the cycle valid stands, bounded wait
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    reg_rd = 1'b1;
    reg_addr = a;
    d = 8'hXX;
    @(posedge clk);
    #1;
    reg_rd = 1'b0;
    reg_addr = ~a;
    for (int n = 0; n < 3; n++) begin
      if (reg_rvalid === 1'b1) begin
        d = reg_rdata;
        break;
      end
      @(posedge clk);
      #1;
    end
    @(posedge clk);
    #1;
  endtask
endmodule

/* dv/test_hdc_hottest_regs.sv */
// self-checking bench of the hottest compare register block
// assumes the host model file and the design files are compiled first
`timescale 1ns/10ps
module test_hdc_hottest_regs;
  import hdc_pkg::*;
  logic        clk, srst, sample_valid, pmax_valid;
  logic        reg_wr, reg_rd, reg_rvalid, alert;
  logic [7:0]  reg_addr, reg_wdata, reg_rdata, d;
  logic [10:0] temp_in [5];
  logic [2:0]  pm1, pm2;
  logic [1:0]  filter_level;
  int          err_count, checks;

  hdc_hottest_regs DUT (.clk(clk), .srst(srst), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid),
    .sample_valid(sample_valid), .temp_in(temp_in),
    .pmax_valid(pmax_valid), .ext1_pmax_frac_in(pm1),
    .ext2_pmax_frac_in(pm2), .filter_level(filter_level), .alert(alert));
  hdc_host_model host (.clk(clk), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
    .reg_rvalid(reg_rvalid));

  // ************************************************************
  // helpers
  // ************************************************************
  always #5 clk = ~clk;
  task automatic chk(string nm, logic [7:0] seen, logic [7:0] exp);
    checks++;
    if (seen !== exp) begin
      err_count++;
      $display("wrong value %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic rchk(logic [7:0] a, logic [7:0] exp);
    host.rd(a, d);
    chk($sformatf("reg %h", a), d, exp);
  endtask
  // one new sample set, result settled a cycle later
  task automatic samp(logic [10:0] t0, t1, t2, t3, t4);
    temp_in = '{t0, t1, t2, t3, t4};
    sample_valid = 1'b1;
    @(posedge clk);
    #1;
    sample_valid = 1'b0;
    @(posedge clk);
    #1;
  endtask
  task automatic summarize();
    if (err_count == 0 && checks > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask

  // ************************************************************
  // scenarios
  // ************************************************************
  task automatic t_reset();
    logic [7:0] ofs [8] = '{8'h4E, 8'h50, 8'h51, 8'h6A, 8'h6B, 8'h6C,
                            8'h6D, 8'h00};
    foreach (ofs[i]) rchk(ofs[i], 8'h00);
    chk("alert", {7'h00, alert}, 8'h00);
  endtask
  task automatic t_filter();
    host.wr(8'h51, 8'hFF);
    rchk(8'h51, 8'h03);
    chk("filter", {6'h00, filter_level}, 8'h03);
    host.wr(8'h51, 8'h02);
    chk("filter", {6'h00, filter_level}, 8'h02);
    host.wr(8'h6A, 8'h55);
    rchk(8'h6A, 8'h00);
  endtask
  task automatic t_compare();
    host.wr(8'h6D, 8'h1F);
    rchk(8'h6D, 8'h1F);
    samp(11'h101, 11'h10B, 11'h185, 11'h182, 11'h17F);
    rchk(8'h6C, 8'h04);
    rchk(8'h6A, 8'h30);
    rchk(8'h6B, 8'hA0);
    host.wr(8'h6D, 8'h1B);
    samp(11'h101, 11'h10B, 11'h185, 11'h182, 11'h17F);
    rchk(8'h6C, 8'h08);
    rchk(8'h6B, 8'h40);
    host.wr(8'h6D, 8'h1F);
    samp(11'h200, 11'h200, 11'h100, 11'h100, 11'h1FF);
    rchk(8'h6C, 8'h01);
    host.wr(8'h6D, 8'h00);
    samp(11'h200, 11'h200, 11'h100, 11'h100, 11'h1FF);
    rchk(8'h6C, 8'h00);
  endtask
  task automatic t_pmax();
    pm1 = 3'd5;
    pm2 = 3'd2;
    pmax_valid = 1'b1;
    @(posedge clk);
    #1;
    pmax_valid = 1'b0;
    pm1 = 3'd0;
    pm2 = 3'd7;
    rchk(8'h50, 8'h40);
    rchk(8'h4E, 8'hA0);
  endtask
  task automatic t_remember();
    host.wr(8'h6D, 8'h1F);
    samp(11'h300, 11'h100, 11'h100, 11'h100, 11'h100);
    host.wr(8'h6D, 8'h3F);
    samp(11'h300, 11'h100, 11'h100, 11'h100, 11'h100);
    chk("alert same", {7'h00, alert}, 8'h00);
    samp(11'h300, 11'h100, 11'h100, 11'h100, 11'h308);
    chk("alert change", {7'h00, alert}, 8'h01);
    rchk(8'h6C, 8'h10);
    host.wr(8'h6D, 8'h1F);
    @(posedge clk);
    #1;
    samp(11'h300, 11'h100, 11'h100, 11'h100, 11'h100);
    chk("alert off", {7'h00, alert}, 8'h00);
  endtask

  // ************************************************************
  // main sequence and watchdog
  // ************************************************************
  initial begin
    clk = 1'b0;
    srst = 1'b1;
    sample_valid = 1'b0;
    pmax_valid = 1'b0;
    pm1 = 3'd0;
    pm2 = 3'd0;
    temp_in = '{default: 11'h000};
    repeat (16) @(posedge clk);
    #1;
    srst = 1'b0;
    t_reset();
    t_filter();
    t_compare();
    t_pmax();
    t_remember();
    // second reset in mid-run must clear every register again
    srst = 1'b1;
    repeat (2) @(posedge clk);
    #1;
    srst = 1'b0;
    t_reset();
    summarize();
  end
  // whole run is about 115 cycles; far past that means a hang
  initial begin
    repeat (5000) @(posedge clk);
    err_count++;
    summarize();
  end
endmodule
